// file: logic/scd_clock_select.sv
// sample clock select and decimation over AXI4-Lite
`timescale 1ns/1ps
// What this block does
// R1: timebase from oscillator, external clock, PLL
// R2: internal source uses host rate id
// R3: user-defined rate selects external connector
// R4: host sets receiver level in percent
// R5: 110-130 MHz PLL, 1 MHz steps, N 1-100000
// R6: host writes step-PLL decimation as N-1
// R7: 500 MHz variant: N of 2, 4, 5k
// R8: 500 MHz variant: also N of 1
// R9: 300-1800 MHz in 1 MHz, N 1 only
// R10: 300-1000 MHz in 1 MHz, N 1 only
// R11: 500-2000 any; to 4000 even, single channel
// R12: 125 or 100 MHz, N 1-100000
// R13: 150-180 MHz in 1 MHz steps, N 1-100000
// R14: fixed 250 MHz, N 1-100000
// R15: 500 MHz variant: N 1, 2, 4, 10k
// R16: fixed 1 GHz: N 1, 2, 4, 10k
// R17: host configures boards before acquisition
// R18: keep one sample of every N
// R19: reject bad request, keep old setting
module scd_clock_select
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // axi4-lite write address
  input  wire logic [scd_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  // axi4-lite write data
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  // axi4-lite write response
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  // axi4-lite read
  input  wire logic [scd_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // timebase control
  output logic [scd_pkg::SRC_W-1:0]         clkSrcSel,
  output logic [scd_pkg::RATE_W-1:0]        intRateId,
  output logic                              pllEnable,
  output logic [scd_pkg::FREQ_W-1:0]        pllFreqMhz,
  output logic [scd_pkg::LEVEL_W-1:0]       extClkLevel,
  // converter samples in, decimated samples out
  input  wire logic                         sampleValid,
  input  wire logic [scd_pkg::SAMPLE_W-1:0] sampleData,
  output logic                              decValid,
  output logic [scd_pkg::SAMPLE_W-1:0]      decData
);
  typedef struct packed {
    logic                awReady;
    logic                awGot;
    logic [ADDR_W-1:0]   awAddr;
    logic                wReady;
    logic                wGot;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                bValid;
    logic [1:0]          bResp;
    logic                arReady;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
    logic [SRC_W-1:0]    src;
    logic [VAR_W-1:0]    variant;
    logic                single;
    logic [RATE_W-1:0]   rateId;
    logic [FREQ_W-1:0]   freq;
    logic [DEC_W-1:0]    decim;
    logic [LEVEL_W-1:0]  level;
    logic [SRC_W-1:0]    actSrc;
    logic [RATE_W-1:0]   actRate;
    logic [FREQ_W-1:0]   actFreq;
    logic [DEC_W-1:0]    actFactor;
    logic                pllEn;
    logic                reject;
    logic                applied;
    logic                restart;
  } scd_state_t;

  scd_state_t s;
  scd_state_t next_s;
  logic                chkOk;
  logic [DEC_W-1:0]    chkFactor;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction : merge

  function automatic logic [31:0] cfgWord(input scd_state_t st);
    logic [31:0] w;
    w = '0;
    w[CFG_SRC_LSB +: SRC_W]   = st.src;
    w[CFG_VAR_LSB +: VAR_W]   = st.variant;
    w[CFG_SINGLE_BIT]         = st.single;
    w[CFG_RATE_LSB +: RATE_W] = st.rateId;
    return w;
  endfunction : cfgWord

  function automatic logic [31:0] statusWord(input scd_state_t st);
    logic [31:0] w;
    w = '0;
    w[ST_REJECT_BIT]         = st.reject;
    w[ST_APPLIED_BIT]        = st.applied;
    w[ST_PLL_BIT]            = st.pllEn;
    w[ST_SRC_LSB +: SRC_W]   = st.actSrc;
    return w;
  endfunction : statusWord

  // judged on staged fields before commit
  scd_req_check u_check (
    .src        (s.src),
    .variant    (s.variant),
    .singleChan (s.single),
    .freqMhz    (s.freq),
    .decimValue (s.decim),
    .reqOk      (chkOk),
    .factor     (chkFactor)
  );

  always_comb
  begin
    logic [31:0] wv;
    wv             = '0;
    next_s         = s;
    next_s.restart = 1'b0;

    // address and data in either order
    if (s.bValid && bready)
      next_s.bValid = 1'b0;
    if (awvalid && s.awReady)
    begin
      next_s.awGot  = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wReady)
    begin
      next_s.wGot  = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (next_s.awGot && next_s.wGot && !next_s.bValid)
    begin
      next_s.awGot  = 1'b0;
      next_s.wGot   = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = RESP_OKAY;
      case (next_s.awAddr)
        OFS_CFG:
        begin
          wv             = merge(cfgWord(s), next_s.wData, next_s.wStrb);
          next_s.src     = wv[CFG_SRC_LSB +: SRC_W];
          next_s.variant = wv[CFG_VAR_LSB +: VAR_W];
          next_s.single  = wv[CFG_SINGLE_BIT];
          next_s.rateId  = wv[CFG_RATE_LSB +: RATE_W];
        end
        OFS_FREQ:
        begin
          wv          = merge(32'(s.freq), next_s.wData,
                              next_s.wStrb);
          next_s.freq = wv[FREQ_W-1:0];
        end
        OFS_DECIM:
        begin
          wv           = merge(32'(s.decim), next_s.wData,
                               next_s.wStrb);
          next_s.decim = wv[DEC_W-1:0];
        end
        OFS_LEVEL:
        begin
          wv = merge(32'(s.level), next_s.wData,
                     next_s.wStrb);
          // level over full scale refused [R4]
          if (wv[31:LEVEL_W] == '0 && wv[LEVEL_W-1:0] <= LEVEL_MAX)
            next_s.level = wv[LEVEL_W-1:0];
          else
            next_s.reject = 1'b1;
        end
        OFS_APPLY:
        begin
          if (next_s.wStrb[0] && next_s.wData[APPLY_BIT])
          begin
            if (chkOk)
            begin
              // source picks oscillator, connector or PLL [R1]
              next_s.actSrc    = s.src; // [R3]
              next_s.actRate   = s.rateId; // [R2]
              next_s.pllEn     = s.src == SRC_PLL_REF;
              next_s.actFreq   = (s.src == SRC_PLL_REF) ? s.freq : '0;
              next_s.actFactor = chkFactor;
              next_s.restart   = 1'b1;
              next_s.applied   = 1'b1;
              next_s.reject    = 1'b0;
            end
            else
              next_s.reject = 1'b1; // [R19]
          end
        end
        OFS_STATUS, OFS_ACT_FREQ, OFS_ACT_DECIM:
          next_s.bResp = RESP_OKAY;
        default:
          next_s.bResp = RESP_SLVERR;
      endcase
    end
    // one write in flight until response drains
    next_s.awReady = !next_s.awGot && !next_s.bValid;
    next_s.wReady  = !next_s.wGot && !next_s.bValid;

    // read path
    if (s.rValid && rready)
    begin
      next_s.rValid  = 1'b0;
      next_s.arReady = 1'b1;
    end
    if (arvalid && s.arReady)
    begin
      next_s.arReady = 1'b0;
      next_s.rValid  = 1'b1;
      next_s.rResp   = RESP_OKAY;
      case (araddr)
        OFS_CFG:       next_s.rData = cfgWord(s);
        OFS_FREQ:      next_s.rData = 32'(s.freq);
        OFS_DECIM:     next_s.rData = 32'(s.decim);
        OFS_LEVEL:     next_s.rData = 32'(s.level);
        OFS_APPLY:     next_s.rData = '0;
        OFS_STATUS:    next_s.rData = statusWord(s);
        OFS_ACT_FREQ:  next_s.rData = 32'(s.actFreq);
        OFS_ACT_DECIM: next_s.rData = 32'(s.actFactor);
        default:
        begin
          next_s.rData = '0;
          next_s.rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s           <= '0;
      s.awReady   <= 1'b1;
      s.wReady    <= 1'b1;
      s.arReady   <= 1'b1;
      s.src       <= SRC_INTERNAL;
      s.actSrc    <= SRC_INTERNAL;
      s.decim     <= DEC_ONE;
      s.actFactor <= DEC_ONE;
      s.level     <= LEVEL_RST;
    end
    else
      s <= next_s;
  end

  // restart realigns the group to the new factor
  scd_decimator u_decim (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .restart  (s.restart),
    .factor   (s.actFactor),
    .inValid  (sampleValid),
    .inData   (sampleData),
    .outValid (decValid),
    .outData  (decData)
  );

  assign awready     = s.awReady;
  assign wready      = s.wReady;
  assign bvalid      = s.bValid;
  assign bresp       = s.bResp;
  assign arready     = s.arReady;
  assign rvalid      = s.rValid;
  assign rdata       = s.rData;
  assign rresp       = s.rResp;
  assign clkSrcSel   = s.actSrc;
  assign intRateId   = s.actRate;
  assign pllEnable   = s.pllEn;
  assign pllFreqMhz  = s.actFreq;
  assign extClkLevel = s.level;
endmodule : scd_clock_select

// file: inc/scd_pkg.sv
// shared constants of the clock select block
package scd_pkg;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int SRC_W    = 2;
  localparam int VAR_W    = 4;
  localparam int RATE_W   = 8;
  localparam int FREQ_W   = 12;
  localparam int DEC_W    = 17;
  localparam int LEVEL_W  = 7;
  localparam int SAMPLE_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CFG       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FREQ      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DECIM     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LEVEL     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_APPLY     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ACT_FREQ  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ACT_DECIM = 8'h1C;

  // field positions
  localparam int CFG_SRC_LSB    = 0;
  localparam int CFG_VAR_LSB    = 4;
  localparam int CFG_SINGLE_BIT = 8;
  localparam int CFG_RATE_LSB   = 16;
  localparam int APPLY_BIT      = 0;
  localparam int ST_REJECT_BIT  = 0;
  localparam int ST_APPLIED_BIT = 1;
  localparam int ST_PLL_BIT     = 2;
  localparam int ST_SRC_LSB     = 4;

  // clock source codes
  localparam logic [SRC_W-1:0] SRC_INTERNAL     = 2'h0;
  localparam logic [SRC_W-1:0] SRC_USER_DEFINED = 2'h1;
  localparam logic [SRC_W-1:0] SRC_PLL_REF      = 2'h2;

  // board variant codes
  localparam logic [VAR_W-1:0] VAR_STEP_110_130 = 4'h0;
  localparam logic [VAR_W-1:0] VAR_F500_A       = 4'h1;
  localparam logic [VAR_W-1:0] VAR_F500_B       = 4'h2;
  localparam logic [VAR_W-1:0] VAR_SYN_1800     = 4'h3;
  localparam logic [VAR_W-1:0] VAR_SYN_1000     = 4'h4;
  localparam logic [VAR_W-1:0] VAR_SYN_4000     = 4'h5;
  localparam logic [VAR_W-1:0] VAR_F100_125     = 4'h6;
  localparam logic [VAR_W-1:0] VAR_STEP_150_180 = 4'h7;
  localparam logic [VAR_W-1:0] VAR_F250         = 4'h8;
  localparam logic [VAR_W-1:0] VAR_F500_C       = 4'h9;
  localparam logic [VAR_W-1:0] VAR_F1000        = 4'hA;

  // frequencies in MHz
  localparam logic [FREQ_W-1:0] PLL_REF_MHZ = 12'h00A;
  localparam logic [FREQ_W-1:0] MHZ_100  = 12'h064;
  localparam logic [FREQ_W-1:0] MHZ_110  = 12'h06E;
  localparam logic [FREQ_W-1:0] MHZ_125  = 12'h07D;
  localparam logic [FREQ_W-1:0] MHZ_130  = 12'h082;
  localparam logic [FREQ_W-1:0] MHZ_150  = 12'h096;
  localparam logic [FREQ_W-1:0] MHZ_180  = 12'h0B4;
  localparam logic [FREQ_W-1:0] MHZ_250  = 12'h0FA;
  localparam logic [FREQ_W-1:0] MHZ_300  = 12'h12C;
  localparam logic [FREQ_W-1:0] MHZ_500  = 12'h1F4;
  localparam logic [FREQ_W-1:0] MHZ_1000 = 12'h3E8;
  localparam logic [FREQ_W-1:0] MHZ_1800 = 12'h708;
  localparam logic [FREQ_W-1:0] MHZ_2000 = 12'h7D0;
  localparam logic [FREQ_W-1:0] MHZ_4000 = 12'hFA0;

  // decimation limits
  localparam logic [DEC_W-1:0] DEC_ONE  = 17'h00001;
  localparam logic [DEC_W-1:0] DEC_TWO  = 17'h00002;
  localparam logic [DEC_W-1:0] DEC_FOUR = 17'h00004;
  localparam logic [DEC_W-1:0] DEC_FIVE = 17'h00005;
  localparam logic [DEC_W-1:0] DEC_TEN  = 17'h0000A;
  localparam logic [DEC_W-1:0] DEC_MAX  = 17'h186A0;
  localparam logic [DEC_W-1:0] DEC_ZERO = 17'h00000;

  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 7'h64;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 7'h32;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scd_pkg

// file: logic/scd_req_check.sv
// judges a staged clock request per variant
`timescale 1ns/1ps
module scd_req_check
  import scd_pkg::*;
(
  // staged request
  input  wire logic [scd_pkg::SRC_W-1:0]  src,
  input  wire logic [scd_pkg::VAR_W-1:0]  variant,
  input  wire logic                       singleChan,
  input  wire logic [scd_pkg::FREQ_W-1:0] freqMhz,
  input  wire logic [scd_pkg::DEC_W-1:0]  decimValue,
  // verdict
  output logic                            reqOk,
  output logic [scd_pkg::DEC_W-1:0]       factor
);
  logic freqOk;
  logic decOk;
  logic inRange;
  logic fixedSet;
  logic mult5;
  logic mult10;

  always_comb
  begin
    // step variants send factor minus one [R6]
    if (src == SRC_PLL_REF && (variant == VAR_STEP_110_130 ||
        variant == VAR_STEP_150_180))
      factor = decimValue + DEC_ONE;
    else
      factor = decimValue;
    inRange  = factor >= DEC_ONE && factor <= DEC_MAX;
    fixedSet = factor == DEC_TWO || factor == DEC_FOUR;
    mult5    = (factor % DEC_FIVE) == DEC_ZERO;
    mult10   = (factor % DEC_TEN) == DEC_ZERO;
    freqOk   = 1'b1;
    decOk    = inRange;
    if (src == SRC_PLL_REF)
    begin
      case (variant)
        VAR_STEP_110_130:
          freqOk = freqMhz >= MHZ_110 && freqMhz <= MHZ_130; // [R5]
        VAR_F500_A:
        begin
          freqOk = freqMhz == MHZ_500;
          decOk  = inRange && (fixedSet || mult5); // [R7]
        end
        VAR_F500_B:
        begin
          freqOk = freqMhz == MHZ_500;
          decOk  = inRange && (factor == DEC_ONE || fixedSet || mult5); // [R8]
        end
        VAR_SYN_1800:
        begin
          freqOk = freqMhz >= MHZ_300 && freqMhz <= MHZ_1800; // [R9]
          decOk  = factor == DEC_ONE;
        end
        VAR_SYN_1000:
        begin
          freqOk = freqMhz >= MHZ_300 && freqMhz <= MHZ_1000; // [R10]
          decOk  = factor == DEC_ONE;
        end
        VAR_SYN_4000:
        begin
          // upper band: even MHz, single channel only [R11]
          freqOk = (freqMhz >= MHZ_500 && freqMhz <= MHZ_2000) ||
                   (freqMhz > MHZ_2000 && freqMhz <= MHZ_4000 &&
                    !freqMhz[0] && singleChan);
          decOk  = factor == DEC_ONE;
        end
        VAR_F100_125:
          freqOk = freqMhz == MHZ_100 || freqMhz == MHZ_125; // [R12]
        VAR_STEP_150_180:
          freqOk = freqMhz >= MHZ_150 && freqMhz <= MHZ_180; // [R13]
        VAR_F250:
          freqOk = freqMhz == MHZ_250; // [R14]
        VAR_F500_C:
        begin
          freqOk = freqMhz == MHZ_500;
          decOk  = inRange && (factor == DEC_ONE || fixedSet || mult10); // [R15]
        end
        VAR_F1000:
        begin
          freqOk = freqMhz == MHZ_1000;
          decOk  = inRange && (factor == DEC_ONE || fixedSet || mult10); // [R16]
        end
        default:
          freqOk = 1'b0;
      endcase
    end
    // unknown source code is refused outright [R19]
    reqOk = freqOk && decOk && src <= SRC_PLL_REF;
  end
endmodule : scd_req_check

// file: logic/scd_decimator.sv
// keeps one sample in every N of the converter stream
`timescale 1ns/1ps
module scd_decimator
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // control
  input  wire logic                         restart,
  input  wire logic [scd_pkg::DEC_W-1:0]    factor,
  // sample stream
  input  wire logic                         inValid,
  input  wire logic [scd_pkg::SAMPLE_W-1:0] inData,
  output logic                              outValid,
  output logic [scd_pkg::SAMPLE_W-1:0]      outData
);
  typedef struct packed {
    logic [DEC_W-1:0]    cnt;
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } scd_dec_state_t;

  scd_dec_state_t s;
  scd_dec_state_t next_s;

  always_comb
  begin
    next_s       = s;
    next_s.valid = 1'b0;
    if (restart)
      next_s.cnt = DEC_ZERO;
    else if (inValid)
    begin
      // first of each N passes [R18]
      if (s.cnt == DEC_ZERO)
      begin
        next_s.valid = 1'b1;
        next_s.data  = inData;
      end
      if (s.cnt >= factor - DEC_ONE)
        next_s.cnt = DEC_ZERO;
      else
        next_s.cnt = s.cnt + DEC_ONE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign outValid = s.valid;
  assign outData  = s.data;
endmodule : scd_decimator

// file: sim/scd_clock_select_sva.sv
// port checks for the clock select block
`timescale 1ns/1ps
module scd_clock_select_sva
  import scd_pkg::*;
(
  // clock and reset
  input logic                        clk,
  input logic                        sys_rst,
  // bus handshakes
  input logic                        awready,
  input logic                        wready,
  input logic [1:0]                  bresp,
  input logic                        bvalid,
  input logic                        bready,
  input logic                        arvalid,
  input logic                        arready,
  input logic                        rvalid,
  // timebase and samples
  input logic [scd_pkg::SRC_W-1:0]   clkSrcSel,
  input logic                        pllEnable,
  input logic [scd_pkg::FREQ_W-1:0]  pllFreqMhz,
  input logic [scd_pkg::LEVEL_W-1:0] extClkLevel,
  input logic                        sampleValid,
  input logic                        decValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("bresp dropped");
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("rvalid late");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write reopened");
  a_read_busy: assert property (rvalid |-> !arready)
    else $error("read reopened");
  a_pll_flag: assert property (pllEnable == (clkSrcSel == SRC_PLL_REF))
    else $error("pll flag wrong");
  a_freq_idle: assert property (!pllEnable |-> pllFreqMhz == 12'h000)
    else $error("stray pll freq");
  a_pll_range: assert property (pllEnable |-> pllFreqMhz >= MHZ_100
    && pllFreqMhz <= MHZ_4000)
    else $error("pll freq range");
  a_level_range: assert property (extClkLevel <= LEVEL_MAX)
    else $error("level too high");
  a_sample_pass: assert property (decValid |-> $past(sampleValid))
    else $error("stray sample");
  a_commit_point: assert property ($changed(clkSrcSel)
    || $changed(pllFreqMhz) |-> $rose(bvalid))
    else $error("commit off write");
endmodule : scd_clock_select_sva

bind scd_clock_select scd_clock_select_sva SVA (.*);

// file: sim/scd_host_model.sv
// bus master acting as the host
`timescale 1ns/1ps
module scd_host_model
  import scd_pkg::*;
(
  // clock
  input  wire logic                      clk,
  // write side
  output logic [scd_pkg::ADDR_W-1:0]     awaddr,
  output logic                           awvalid,
  input  wire logic                      awready,
  output logic [31:0]                    wdata,
  output logic [3:0]                     wstrb,
  output logic                           wvalid,
  input  wire logic                      wready,
  input  wire logic [1:0]                bresp,
  input  wire logic                      bvalid,
  output logic                           bready,
  // read side
  output logic [scd_pkg::ADDR_W-1:0]     araddr,
  output logic                           arvalid,
  input  wire logic                      arready,
  input  wire logic [31:0]               rdata,
  input  wire logic [1:0]                rresp,
  input  wire logic                      rvalid,
  output logic                           rready
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    forever
    begin
      @(posedge clk);
      // released lines show the inverse
      if (awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wready) {wvalid, wdata} <= {1'b0, ~d};
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    forever
    begin
      @(posedge clk);
      if (arready) {arvalid, araddr} <= {1'b0, ~a};
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  // timebase setup except receiver level, then commit
  task automatic cfg(input logic [1:0] s, input logic [3:0] v, input logic sg,
                     input logic [7:0] rt, input logic [11:0] f,
                     input logic [16:0] n, output logic [1:0] r);
    logic [16:0] dv;
    logic [1:0]  q;
    dv = (s == SRC_PLL_REF && (v == VAR_STEP_110_130
          || v == VAR_STEP_150_180)) ? n - 17'h00001 : n;
    wr(OFS_CFG, {8'h00, rt, 7'h00, sg, v, 2'h0, s}, q);
    wr(OFS_FREQ, 32'(f), q);
    wr(OFS_DECIM, 32'(dv), q);
    wr(OFS_APPLY, 32'h00000001, r);
  endtask : cfg
endmodule : scd_host_model

// file: sim/tb_top.sv
// self-checking bench for the clock select
`timescale 1ns/1ps
module tb_top;
  import scd_pkg::*;
  logic                clk, sys_rst, awvalid, awready, wvalid, wready;
  logic                bvalid, bready, arvalid, arready, rvalid, rready;
  logic                pllEnable, sampleValid, decValid;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic [31:0]         wdata, rdata, rdv;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, rsp, eSrc;
  logic [SRC_W-1:0]    clkSrcSel;
  logic [RATE_W-1:0]   intRateId;
  logic [FREQ_W-1:0]   pllFreqMhz, eFreq, f;
  logic [LEVEL_W-1:0]  extClkLevel, lv;
  logic [SAMPLE_W-1:0] sampleData, decData;
  logic [SAMPLE_W-1:0] expQ[$];
  logic [DEC_W-1:0]    eN, n;
  logic [11:0]         goodF[12] = '{120, 500, 500, 1382, 882, 2500, 125,
                                     150, 250, 500, 1000, 500};
  logic [16:0]         nList[11] = '{0, 1, 2, 3, 4, 5, 10, 20, 25, 100000,
                                     100001};
  int                  fail_count, cmp_count;

  scd_clock_select DUT (.*);
  scd_host_model HOST (.*);

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  function automatic logic okReq(input logic [1:0] s, input logic [3:0] v,
    input logic sg, input logic [11:0] f, input logic [16:0] n);
    logic m;
    m = (n == 2 || n == 4);
    if (n < 1 || n > 100000) return 1'b0;
    if (s != SRC_PLL_REF) return 1'b1;
    case (v)
      VAR_STEP_110_130: return f >= 110 && f <= 130;
      VAR_F500_A: return f == 500 && (m || n % 5 == 0);
      VAR_F500_B: return f == 500 && (m || n == 1 || n % 5 == 0);
      VAR_SYN_1800: return f >= 300 && f <= 1800 && n == 1;
      VAR_SYN_1000: return f >= 300 && f <= 1000 && n == 1;
      VAR_SYN_4000: return n == 1 && f >= 500 && (f <= 2000
        || (f <= 4000 && f % 2 == 0 && sg));
      VAR_F100_125: return f == 100 || f == 125;
      VAR_STEP_150_180: return f >= 150 && f <= 180;
      VAR_F250: return f == 250;
      VAR_F500_C: return f == 500 && (m || n == 1 || n % 10 == 0);
      VAR_F1000: return f == 1000 && (m || n == 1 || n % 10 == 0);
      default: return 1'b0;
    endcase
  endfunction : okReq

  task automatic apply(input logic [1:0] s, input logic [3:0] v,
                       input logic [11:0] f, input logic [16:0] n);
    logic [7:0] rt;
    logic       sg, ok;
    rt = 8'($urandom);
    sg = 1'($urandom);
    ok = okReq(s, v, sg, f, n);
    HOST.cfg(s, v, sg, rt, f, n, rsp);
    if (ok)
    begin
      {eSrc, eN} = {s, n};
      eFreq = (s == SRC_PLL_REF) ? f : 12'h000;
      if (s == SRC_INTERNAL) chk(32'(intRateId), 32'(rt), "rate id");
    end
    HOST.rd(OFS_STATUS, rdv, rsp);
    chk(32'(rdv[ST_REJECT_BIT]), 32'(!ok), "reject flag");
    chk(32'(clkSrcSel), 32'(eSrc), "source");
    chk(32'(pllFreqMhz), 32'(eFreq), "pll freq");
    HOST.rd(OFS_ACT_DECIM, rdv, rsp);
    chk(rdv, 32'(eN), "factor");
  endtask : apply

  task automatic stream(input int cnt);
    logic vld;
    logic [15:0] dat;
    int c;
    c = 0;
    for (int i = 0; i < cnt; i++)
    begin
      @(posedge clk);
      vld = (i < cnt / 2) ? 1'b1 : 1'($urandom);
      dat = 16'($urandom);
      sampleValid <= vld;
      sampleData <= dat;
      if (vld && c++ % eN == 0) expQ.push_back(dat);
    end
    @(posedge clk);
    sampleValid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(expQ.size()), 32'h00000000, "samples lost");
  endtask : stream

  always @(posedge clk)
    if (decValid === 1'b1)
    begin
      if (expQ.size() == 0) chk(32'(decData), 32'hFFFFFFFF, "extra out");
      else chk(32'(decData), 32'(expQ.pop_front()), "kept sample");
    end

  initial
  begin
    #300_000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    {sys_rst, sampleValid, sampleData} = {1'b1, 1'b0, 16'h0000};
    {fail_count, cmp_count} = 0;
    {eSrc, eFreq, eN} = {SRC_INTERNAL, 12'h000, DEC_ONE};
    void'($urandom(32'hD069));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(32'(extClkLevel), 32'd50, "level reset");
    HOST.rd(OFS_ACT_DECIM, rdv, rsp);
    chk(rdv, 32'h00000001, "factor reset");
    $display("test reset done");
    HOST.rd(8'h40, rdv, rsp);
    chk(rdv, 32'h00000000, "bad read data");
    chk(32'(rsp), 32'(RESP_SLVERR), "bad read");
    HOST.wr(8'h40, 32'hFFFFFFFF, rsp);
    chk(32'(rsp), 32'(RESP_SLVERR), "bad write");
    HOST.wr(OFS_ACT_FREQ, 32'h00000123, rsp);
    HOST.rd(OFS_ACT_FREQ, rdv, rsp);
    chk(rdv, 32'h00000000, "ro write");
    $display("test bus done");
    for (int i = 0; i < 4; i++)
    begin
      lv = (i == 0) ? 7'h64 : (i == 1) ? 7'h00 : 7'($urandom_range(0, 100));
      HOST.wr(OFS_LEVEL, 32'(lv), rsp);
      chk(32'(extClkLevel), 32'(lv), "level");
    end
    HOST.wr(OFS_LEVEL, 32'd101, rsp);
    chk(32'(extClkLevel), 32'(lv), "level kept");
    HOST.rd(OFS_STATUS, rdv, rsp);
    chk(32'(rdv[ST_REJECT_BIT]), 32'h00000001, "level reject");
    $display("test level done");
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 11; k++)
        apply(2'(s), 4'h0, 12'h000, nList[k]);
    $display("test sources done");
    for (int v = 0; v < 12; v++)
      repeat (6)
      begin
        f = goodF[v] + 12'($urandom_range(0, 2)) - 12'h001;
        if ($urandom_range(0, 3) == 0) f = 12'($urandom_range(90, 4095));
        n = nList[$urandom_range(0, 10)];
        if ($urandom_range(0, 3) == 0) n = 17'($urandom_range(1, 100000));
        apply(SRC_PLL_REF, 4'(v), f, n);
      end
    $display("test pll variants done");
    apply(SRC_INTERNAL, 4'h0, 12'h000, 17'h00004);
    stream(40);
    apply(SRC_PLL_REF, VAR_STEP_150_180, MHZ_150, 17'h00007);
    stream(50);
    apply(SRC_USER_DEFINED, 4'h0, 12'h000, DEC_ONE);
    stream(20);
    $display("test decimation done");
    report_and_stop();
  end
endmodule : tb_top
